/* include/sli_params.svh */
// timing counts and register map of the status indicator block
`ifndef SLI_PARAMS_SVH
`define SLI_PARAMS_SVH

// register byte offsets
`define SLI_OFF_CTRL 12'h000
`define SLI_OFF_STATUS 12'h004
`define SLI_OFF_IRQ_STAT 12'h008
`define SLI_OFF_IRQ_MASK 12'h00C
`define SLI_OFF_LEDS 12'h010
`define SLI_OFF_LOCATE 12'h014

// control register fields
`define SLI_CTRL_INIT 0
`define SLI_CTRL_MODE_CHG 1
`define SLI_CTRL_FW_UPD 2
`define SLI_CTRL_FORCE_EN 3
`define SLI_CTRL_FORCE_625 4
`define SLI_CTRL_CFG_ERR 5
`define SLI_CTRL_RESET 32'h0000_0001

// interrupt status bits
`define SLI_IRQ_FAULT 0
`define SLI_IRQ_STD_CHG 1
`define SLI_IRQ_VID_CHG 2
`define SLI_IRQ_LOCATE 3
`define SLI_IRQ_WIDTH 4

// timing in milliseconds and derived cycle counts at 250 MHz
`define SLI_CLK_KHZ 250000
`define SLI_SHORT_MS 50
`define SLI_LONG_MS 2000
`define SLI_BLINK_MS 250
`define SLI_SHORT_CYC (`SLI_SHORT_MS * `SLI_CLK_KHZ)
`define SLI_LONG_CYC (`SLI_LONG_MS * `SLI_CLK_KHZ)
`define SLI_BLINK_CYC (`SLI_BLINK_MS * `SLI_CLK_KHZ)

`endif

/* include/sli_pkg.sv */
// types shared by the status indicator block
package sli_pkg;

    // detected standard of the input
    typedef enum logic [1:0] {
        sli_std_none,
        sli_std_525,
        sli_std_625
    } sli_std_t;

    // group of indicator drive levels
    typedef struct packed {
        logic fault_indicator;
        logic bus_activity_indicator;
        logic setup_activity_indicator;
        logic std525_indicator;
        logic forced_standard_indicator;
        logic std625_indicator;
        logic video_present_indicator;
        logic upper_bank_indicator;
    } sli_leds_t;

    // conditions sensed outside the module, fed in on the cond port
    typedef struct packed {
        logic cpu_fault;
        logic logic_cfg_fault;
        logic input_cfg_err;
        logic bus_traffic;
        logic locate_cmd;
        logic toggle_held;
        sli_std_t det_std;
        logic sync_valid;
        logic bank_upper;
    } sli_cond_t;

endpackage : sli_pkg

/* src/sli_pulse_timer.sv */
// retriggerable one-shot that holds its output for a set count
`timescale 1ns/1ns
module sli_pulse_timer
    import sli_pkg::*;
#(
    parameter int CW = 32,
    parameter logic [CW-1:0] COUNT = 100
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // trigger and output
    input wire logic trigger,
    output logic active
);
    // elaboration check: a zero count would never light the output
    if (COUNT == '0) begin : g_bad_count
        $error("sli_pulse_timer: count must be nonzero");
    end

    logic [CW-1:0] remain;
    wire logic [CW-1:0] next_remain = trigger ? COUNT :
        (remain != '0) ? remain - 1'b1 : remain;

    // countdown, restarted by each trigger
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) remain <= '0;
        else remain <= next_remain;
    end

    assign active = (remain != '0);
endmodule : sli_pulse_timer

/* src/sli_blinker.sv */
// square-wave blinker whose half period is set by a load value
`timescale 1ns/1ns
module sli_blinker
    import sli_pkg::*;
#(
    parameter int CW = 32
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // half period in cycles and phase output
    input wire logic [CW-1:0] half_period,
    output logic phase
);
    logic [CW-1:0] cnt;
    wire logic wrap = (cnt >= half_period);

    // free-running counter toggles the phase on wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
            phase <= 1'b0;
        end else begin
            cnt <= wrap ? '0 : cnt + 1'b1;
            phase <= wrap ? ~phase : phase;
        end
    end
endmodule : sli_blinker

/* src/sli_status_led_indicator.sv */
// front-panel status indicator logic with an apb register file
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ns
`include "sli_params.svh"

// Behaviour
// - fault steady on processor/logic configuration fault
// - fault blinks on input/settings configuration problem
// - bus indicator dark without bus traffic
// - bus indicator long blink on locate
// - bus indicator short blinks during traffic
// - setup steady while initializing, changing, updating
// - setup blinks, faster the longer toggle held
// - 525 steady on 525 input, else dark
// - 525 blinks if forced but input 625
// - 625 steady on 625 input, else dark
// - 625 blinks if forced but input 525
// - forced indicator lit when standard forced
// - auto mode indicators follow detected standard
// - video present only with valid sync
// - upper bank indicator follows second bank
module sli_status_led_indicator
    import sli_pkg::*;
#(
    parameter int CW = 32,
    parameter logic [CW-1:0] SHORT_CYC = CW'(`SLI_SHORT_CYC),
    parameter logic [CW-1:0] LONG_CYC = CW'(`SLI_LONG_CYC),
    parameter logic [CW-1:0] BLINK_CYC = CW'(`SLI_BLINK_CYC),
    parameter logic [CW-1:0] HOLD_STEP_CYC = CW'(`SLI_BLINK_CYC)
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sensed conditions
    input wire sli_cond_t cond,
    // indicator drives and interrupt
    output sli_leds_t leds,
    output logic irq
);
    // elaboration checks on the counter width and timing counts
    if (CW < 8 || CW > 32) begin : g_bad_cw
        $error("sli: counter width out of range");
    end
    if (LONG_CYC <= SHORT_CYC) begin : g_bad_long
        $error("sli: long blink must exceed short");
    end
    if (BLINK_CYC < 4) begin : g_bad_blink
        $error("sli: blink period too small");
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic [31:0] ctrl;
    logic [`SLI_IRQ_WIDTH-1:0] irq_stat;
    logic [`SLI_IRQ_WIDTH-1:0] irq_mask;
    logic sw_locate;

    // access phase strobes; slave answers with no wait state
    wire logic access = psel && penable;
    wire logic wr_en = access && pwrite;
    wire logic rd_en = access && !pwrite;
    wire logic hit_ctrl = (paddr == `SLI_OFF_CTRL);
    wire logic hit_status = (paddr == `SLI_OFF_STATUS);
    wire logic hit_istat = (paddr == `SLI_OFF_IRQ_STAT);
    wire logic hit_imask = (paddr == `SLI_OFF_IRQ_MASK);
    wire logic hit_leds = (paddr == `SLI_OFF_LEDS);
    wire logic hit_locate = (paddr == `SLI_OFF_LOCATE);
    wire logic mapped = hit_ctrl | hit_status | hit_istat | hit_imask | hit_leds | hit_locate;

    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // byte-lane merge of write data into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = wd[i*8 +: 8];
        end
        return r;
    endfunction : merge

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    wire logic [31:0] next_ctrl = (wr_en && hit_ctrl) ? merge(ctrl, pwdata, pstrb) : ctrl;
    wire logic [31:0] wmask = merge(32'h0000_0000, pwdata, pstrb);

    // software-held mode bits and forcing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ctrl <= `SLI_CTRL_RESET;
        else ctrl <= next_ctrl;
    end

    // software locate request, one-cycle pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sw_locate <= 1'b0;
        else sw_locate <= wr_en && hit_locate && pwdata[0];
    end

    wire logic setup_busy = ctrl[`SLI_CTRL_INIT] | ctrl[`SLI_CTRL_MODE_CHG]
                          | ctrl[`SLI_CTRL_FW_UPD];
    wire logic force_en = ctrl[`SLI_CTRL_FORCE_EN];
    wire logic force_625 = ctrl[`SLI_CTRL_FORCE_625];
    wire logic cfg_err = ctrl[`SLI_CTRL_CFG_ERR] | cond.input_cfg_err;

    // ------------------------------------------------------------
    // timers and blink sources
    // ------------------------------------------------------------
    logic slow_phase;
    logic short_on;
    logic long_on;
    logic toggle_phase;
    logic traffic_q;
    wire logic locate_evt = cond.locate_cmd | sw_locate;
    wire logic traffic_rise = cond.bus_traffic && !traffic_q;

    // steady blink for fault and standard mismatch
    sli_blinker #(.CW(CW)) u_slow (
        .pclk(pclk),
        .presetn(presetn),
        .half_period(BLINK_CYC),
        .phase(slow_phase)
    );

    // short flash retriggered while traffic runs
    sli_pulse_timer #(.CW(CW), .COUNT(SHORT_CYC)) u_short (
        .pclk(pclk),
        .presetn(presetn),
        .trigger(traffic_rise),
        .active(short_on)
    );

    // long flash on a locate command
    sli_pulse_timer #(.CW(CW), .COUNT(LONG_CYC)) u_long (
        .pclk(pclk),
        .presetn(presetn),
        .trigger(locate_evt),
        .active(long_on)
    );

    // traffic edge memory; clears when the short flash ends, so ongoing traffic starts a new one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) traffic_q <= 1'b0;
        else traffic_q <= cond.bus_traffic && short_on;
    end

    // ------------------------------------------------------------
    // toggle hold acceleration
    // ------------------------------------------------------------
    logic [CW-1:0] hold_cnt;
    logic [1:0] speed;
    wire logic hold_step = (hold_cnt >= HOLD_STEP_CYC);
    wire logic [1:0] next_speed = !cond.toggle_held ? 2'b00 :
        (hold_step && speed != 2'b11) ? speed + 2'b01 : speed;
    wire logic [CW-1:0] toggle_half = BLINK_CYC >> speed;

    // hold timer steps the speed up the longer the switch is held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt <= '0;
            speed <= 2'b00;
        end else begin
            hold_cnt <= (!cond.toggle_held || hold_step) ? '0 : hold_cnt + 1'b1;
            speed <= next_speed;
        end
    end

    // adjustment rate blink, half period is the blink count shifted right by speed
    sli_blinker #(.CW(CW)) u_toggle (
        .pclk(pclk),
        .presetn(presetn),
        .half_period(toggle_half),
        .phase(toggle_phase)
    );

    // ------------------------------------------------------------
    // indicator decode
    // ------------------------------------------------------------
    wire logic hard_fault = cond.cpu_fault | cond.logic_cfg_fault;
    wire logic is525 = (cond.det_std == sli_std_525);
    wire logic is625 = (cond.det_std == sli_std_625);
    wire logic mism525 = force_en && !force_625 && is625;
    wire logic mism625 = force_en && force_625 && is525;
    sli_leds_t next_leds;

    assign next_leds.fault_indicator = hard_fault ? 1'b1
        : cfg_err ? slow_phase : 1'b0;
    assign next_leds.bus_activity_indicator = long_on ? 1'b1
        : (cond.bus_traffic || short_on) ? short_on
        : 1'b0;
    assign next_leds.setup_activity_indicator = setup_busy ? 1'b1
        : cond.toggle_held ? toggle_phase : 1'b0;
    assign next_leds.std525_indicator = mism525 ? slow_phase
        : is525;
    assign next_leds.std625_indicator = mism625 ? slow_phase
        : is625;
    assign next_leds.forced_standard_indicator = force_en;
    assign next_leds.video_present_indicator = (cond.det_std != sli_std_none)
        && cond.sync_valid;
    assign next_leds.upper_bank_indicator = cond.bank_upper;

    // registered indicator drives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) leds <= '0;
        else leds <= next_leds;
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    logic [1:0] std_q;
    logic vid_q;
    logic fault_q;
    wire logic fault_now = hard_fault | cfg_err;
    wire logic [`SLI_IRQ_WIDTH-1:0] events = {
        locate_evt,
        next_leds.video_present_indicator != vid_q,
        cond.det_std != sli_std_t'(std_q),
        fault_now && !fault_q
    };
    wire logic [`SLI_IRQ_WIDTH-1:0] w1c = (wr_en && hit_istat) ?
        wmask[`SLI_IRQ_WIDTH-1:0] : '0;
    wire logic [`SLI_IRQ_WIDTH-1:0] next_irq_stat = (irq_stat & ~w1c) | events;

    // sticky status, set wins over clear; mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
            irq_mask <= '0;
            std_q <= 2'b00;
            vid_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq_mask <= (wr_en && hit_imask) ? wmask[`SLI_IRQ_WIDTH-1:0] : irq_mask;
            std_q <= cond.det_std;
            vid_q <= next_leds.video_present_indicator;
            fault_q <= fault_now;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    wire logic [31:0] status_word = {21'h0, speed, fault_now, long_on, short_on,
                                      cond.bank_upper, cond.sync_valid, cond.det_std,
                                      hard_fault, cfg_err};
    wire logic [31:0] next_prdata =
        !rd_en ? 32'h0000_0000 :
        hit_ctrl ? ctrl :
        hit_status ? status_word :
        hit_istat ? {28'h0, irq_stat} :
        hit_imask ? {28'h0, irq_mask} :
        hit_leds ? {24'h0, leds} : 32'h0000_0000;

    // read data is taken at the access edge, combinational from state
    assign prdata = next_prdata;

endmodule : sli_status_led_indicator

/* testbench/sli_panel_viewer.sv */
// operator side of the panel: counts how often each indicator lights
`timescale 1ns/1ns
module sli_panel_viewer
    import sli_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // indicators seen and counts
    input wire sli_leds_t leds,
    input wire logic clr,
    output logic [7:0][7:0] rises
);
    logic [7:0] last;
    // count rising edges, so a blink is told apart from steady light
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last <= 8'h00;
            rises <= '0;
        end else begin
            last <= leds;
            for (int i = 0; i < 8; i++) begin
                if (clr) begin
                    rises[i] <= 8'h00;
                end else if (leds[i] && !last[i] && rises[i] != 8'hff) begin
                    rises[i] <= rises[i] + 8'h01;
                end
            end
        end
    end
endmodule : sli_panel_viewer

/* testbench/sli_status_led_indicator_checker.sv */
// assertions on the status indicator ports
`timescale 1ns/1ns
module sli_status_led_indicator_checker
    import sli_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // conditions and indicators
    input wire sli_cond_t cond,
    input wire sli_leds_t leds,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access phase and locate write decode
    wire acc = psel && penable;
    wire loc_wr = acc && pwrite && paddr == 12'h014 && pwdata[0];
    sequence s_locate;
        cond.locate_cmd;
    endsequence
    sequence s_long;
        leds.bus_activity_indicator [*8];
    endsequence
    chk_apb_ready: assert property (acc |-> pready)
        else $error("access without ready");
    chk_unmapped_error: assert property (acc && paddr > 12'h014 |-> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    chk_fault_steady: assert property ($past(presetn) && $past(cond.cpu_fault) |->
        leds.fault_indicator) else $error("fault not lit");
    chk_video_follow: assert property ($past(presetn) |-> leds.video_present_indicator ==
        $past(cond.sync_valid && cond.det_std != sli_std_none)) else $error("video wrong");
    chk_bank_follow: assert property ($past(presetn) |->
        leds.upper_bank_indicator == $past(cond.bank_upper)) else $error("bank wrong");
    chk_std_dark: assert property ($past(presetn) && $past(cond.det_std) == sli_std_none |->
        !leds.std525_indicator && !leds.std625_indicator) else $error("std lit");
    chk_bus_cause: assert property ($rose(leds.bus_activity_indicator) |->
        $past(cond.bus_traffic) || $past(cond.bus_traffic, 2) || $past(cond.locate_cmd) ||
        $past(cond.locate_cmd, 2) || $past(loc_wr) || $past(loc_wr, 2) ||
        $past(loc_wr, 3)) else $error("bus lit without cause");
    chk_locate_long: assert property (s_locate |=> ##1 s_long)
        else $error("locate blink short");
endmodule : sli_status_led_indicator_checker

bind sli_status_led_indicator sli_status_led_indicator_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cond(cond), .leds(leds), .irq(irq)
);

/* testbench/tb.sv */
// self-checking bench for the status indicator block
`timescale 1ns/1ns
module tb;
    import sli_pkg::*;
    typedef struct {string nm; int src; logic [31:0] exp;} sli_note_t;
    logic pclk, presetn, psel, penable, pwrite, clr, pready, pslverr, irq, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [7:0] early;
    logic [7:0][7:0] rises;
    sli_cond_t cond;
    sli_leds_t leds;
    sli_note_t q[$];
    int bad_count, n_compared;
    event abort_ev;

    sli_status_led_indicator #(.SHORT_CYC(32'h0000_0008), .LONG_CYC(32'h0000_0040),
        .BLINK_CYC(32'h0000_0010), .HOLD_STEP_CYC(32'h0000_0020)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cond(cond), .leds(leds), .irq(irq));
    sli_panel_viewer u_view (.pclk(pclk), .presetn(presetn), .leds(leds), .clr(clr),
        .rises(rises));

    // clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // take every queued note, oldest first, whenever outputs have settled and compare
    always @(negedge pclk) begin
        logic [31:0] got;
        while (q.size() > 0) begin
            case (q[0].src)
                0: got = 32'(leds);
                1: got = rd;
                2: got = 32'(irq);
                3: got = 32'(er);
                4: got = 32'(rises[5] > early);
                default: got = q[0].src >= 16 ? 32'(leds[q[0].src - 16]) :
                    32'(rises[q[0].src - 8] > 8'h01);
            endcase
            n_compared++;
            if (got !== q[0].exp) begin
                bad_count++;
                $display("wrong value %s expected %h seen %h", q[0].nm, q[0].exp, got);
            end
            void'(q.pop_front());
        end
    end

    // a bus wait that ran out ends the run through the one closing report
    initial begin
        @(abort_ev);
        print_verdict();
    end

    task note(input string nm, input int src, input logic [31:0] exp);
        q.push_back('{nm, src, exp});
    endtask : note

    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    task clrp;
        clr <= 1'b1;
        tick(1);
        clr <= 1'b0;
    endtask : clrp

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (n >= 20) begin
            bad_count++;
            -> abort_ev;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task print_verdict;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    // main sequence
    initial begin
        sli_cond_t c;
        logic [31:0] r;
        void'($urandom(3));
        {presetn, psel, penable, pwrite, clr} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        cond = '0;
        early = 8'h00;
        tick(4);
        presetn <= 1'b1;
        tick(2);
        note("leds reset", 0, 32'h0000_0020);
        apb(1'b0, 12'h000, 32'h0000_0000);
        note("ctrl reset", 1, 32'h0000_0001);
        apb(1'b1, 12'h000, 32'h0000_0000);
        tick(1);
        note("leds idle", 0, 32'h0000_0000);
        $display("reset test done");
        for (int i = 0; i < 10; i++) begin
            r = $urandom;
            c = '0;
            {c.cpu_fault, c.logic_cfg_fault, c.sync_valid, c.bank_upper} = r[3:0];
            c.det_std = sli_std_t'(r[5:4] % 2'h3);
            cond <= c;
            tick(2);
            note("leds", 0, 32'({c.cpu_fault | c.logic_cfg_fault, 2'h0,
                c.det_std == sli_std_525, 1'h0, c.det_std == sli_std_625,
                c.sync_valid && c.det_std != sli_std_none, c.bank_upper}));
        end
        $display("steady test done");
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 12'h000, k ? 32'h0000_0018 : 32'h0000_0008);
            c = '0;
            c.sync_valid = 1'b1;
            c.det_std = k ? sli_std_525 : sli_std_625;
            cond <= c;
            clrp();
            tick(80);
            note("forced", 19, 1);
            note("std blink", k ? 10 : 12, 1);
            note("std steady", k ? 20 : 18, 1);
        end
        for (int j = 0; j < 2; j++) begin
            apb(1'b1, 12'h000, j ? 32'h0000_0000 : 32'h0000_0020);
            c = '0;
            c.input_cfg_err = j[0];
            cond <= c;
            clrp();
            tick(80);
            note("fault blink", 15, 1);
        end
        $display("blink test done");
        c = '0;
        c.toggle_held = 1'b1;
        cond <= c;
        clrp();
        tick(32);
        early = rises[5];
        tick(64);
        clrp();
        tick(32);
        note("toggle rate", 4, 1);
        c = '0;
        c.bus_traffic = 1'b1;
        cond <= c;
        tick(3);
        note("bus short", 22, 1);
        c.bus_traffic = 1'b0;
        cond <= c;
        tick(20);
        note("bus dark", 22, 0);
        c.locate_cmd = 1'b1;
        cond <= c;
        tick(1);
        c.locate_cmd = 1'b0;
        cond <= c;
        tick(30);
        note("bus long", 22, 1);
        tick(60);
        note("bus long end", 22, 0);
        apb(1'b1, 12'h014, 32'h0000_0001);
        tick(30);
        note("bus locate", 22, 1);
        tick(60);
        $display("bus test done");
        apb(1'b1, 12'h00C, 32'h0000_000F);
        apb(1'b1, 12'h008, 32'h0000_000F);
        note("irq idle", 2, 0);
        c.cpu_fault = 1'b1;
        cond <= c;
        tick(3);
        note("irq raised", 2, 1);
        apb(1'b0, 12'h008, 32'h0000_0000);
        note("irq status", 1, 1);
        apb(1'b1, 12'h00C, 32'h0000_0000);
        note("irq masked", 2, 0);
        apb(1'b1, 12'h00C, 32'h0000_0001);
        note("irq unmasked", 2, 1);
        apb(1'b1, 12'h008, 32'h0000_0001);
        note("irq cleared", 2, 0);
        for (int m = 1; m < 3; m++) begin
            apb(1'b1, 12'h000, 32'(m) << 1);
            note("setup busy", 21, 1);
        end
        apb(1'b1, 12'h000, 32'h0000_0000);
        apb(1'b0, 12'h010, 32'h0000_0000);
        note("leds register", 1, 32'h0000_0080);
        apb(1'b0, 12'h020, 32'h0000_0000);
        note("unmapped data", 1, 0);
        note("unmapped error", 3, 1);
        $display("register test done");
        tick(2);
        print_verdict();
    end
endmodule : tb
